// >>> src/ofc_top.sv
// module: output formatter registers, sample coding and sticky overrange flags
`timescale 1ns/1ps
//
// Functional notes
// - user pattern words two to four, low and high bytes, reset zero, feed pattern mode
// - sample invert bit set inverts each sample before coding
// - one clear bit per converter; one holds that converter's overrange flag cleared
// - read-only byte of sticky overrange flags per converter, reset zero
module ofc_top
  import ofc_pkg::*;
#(
  parameter int SAMPLE_W = 14
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic sample_valid,
  input wire logic [SAMPLE_W-1:0] sample_in,
  input wire logic [2:0] conv_idx,
  input wire logic overrange_in,
  input wire logic fast_threshold_flag,
  input wire logic sysref_pin,
  input wire logic [1:0] ctrl_bit_count,
  input wire logic user_pattern_mode,
  input wire logic [1:0] pattern_word_sel,
  output logic [SAMPLE_W-1:0] out_sample,
  output logic [OFC_NUM_CTRL-1:0] out_ctrl,
  output logic out_valid
);
  typedef struct packed {
    logic [7:0] pat_two_low;
    logic [7:0] pat_two_high;
    logic [7:0] pat_three_low;
    logic [7:0] pat_three_high;
    logic [7:0] pat_four_low;
    logic [7:0] pat_four_high;
    logic [7:0] src_upper;
    logic [7:0] src_lower;
    logic [7:0] fmt;
    logic [7:0] ovr_clear;
    logic [7:0] ovr_status;
    logic [7:0] rdata;
    logic rvalid;
    logic sysref_meta;
    logic sysref_sync;
    logic [SAMPLE_W-1:0] smp;
    logic [OFC_NUM_CTRL-1:0] ctl;
    logic vld;
  } ofc_state_t;

  ofc_state_t st;
  ofc_state_t next_st;
  ofc_sel_if sel_bus[OFC_NUM_CTRL] ();
  logic [OFC_NUM_CTRL-1:0] sel_bits;
  logic [2:0] src_code[OFC_NUM_CTRL];
  logic ovr_live;
  logic [15:0] pat_word;
  logic [SAMPLE_W-1:0] inv_smp;
  logic [SAMPLE_W-1:0] coded_smp;
  logic [7:0] ovr_event;

  ////////////////////////////////////////////////////////////////////////////
  // control bit selectors

  assign src_code[0] = st.src_upper[OFC_SRC_BIT0_LSB +: 3];
  assign src_code[1] = st.src_upper[OFC_SRC_BIT1_LSB +: 3];
  assign src_code[2] = st.src_lower[OFC_SRC_BIT2_LSB +: 3];
  // a cleared converter shows no overrange on its control bit either
  assign ovr_live = overrange_in & ~st.ovr_clear[conv_idx];

  genvar gi;
  generate
    for (gi = 0; gi < OFC_NUM_CTRL; gi++) begin : g_sel
      assign sel_bus[gi].src = src_code[gi];
      assign sel_bus[gi].en = (ctrl_bit_count > 2'(gi));
      assign sel_bus[gi].ovr = ovr_live;
      assign sel_bus[gi].fast = fast_threshold_flag;
      assign sel_bus[gi].sysref = st.sysref_sync;
      assign sel_bits[gi] = sel_bus[gi].bit_out;
      ofc_ctrl_sel u_sel (
        .port(sel_bus[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // sample path

  always_comb begin
    pat_word = {st.pat_two_high, st.pat_two_low};
    if (pattern_word_sel == 2'h1) begin
      pat_word = {st.pat_three_high, st.pat_three_low};
    end else if (pattern_word_sel == 2'h2) begin
      pat_word = {st.pat_four_high, st.pat_four_low};
    end
  end

  // incoming samples are twos complement; offset binary flips the sign bit
  assign inv_smp = st.fmt[OFC_INVERT_BIT] ? ~sample_in : sample_in;
  assign coded_smp = (st.fmt[OFC_FMT_SEL_LSB +: 2] == OFC_FMT_OFFSET_BINARY) ?
                     {~inv_smp[SAMPLE_W-1], inv_smp[SAMPLE_W-2:0]} : inv_smp;

  assign ovr_event = (sample_valid && overrange_in) ? (8'h01 << conv_idx) : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.sysref_meta = sysref_pin;
    next_st.sysref_sync = st.sysref_meta;
    next_st.vld = sample_valid;
    if (sample_valid) begin
      if (user_pattern_mode) begin
        next_st.smp = pat_word[15 -: SAMPLE_W];
        next_st.ctl = {1'b0, pat_word[1:0]};
      end else begin
        next_st.smp = coded_smp;
        next_st.ctl = sel_bits;
      end
    end
    if (cfg_wr) begin
      if (cfg_addr == OFC_ADDR_PAT_TWO_LOW) begin
        next_st.pat_two_low = cfg_wdata;
      end else if (cfg_addr == OFC_ADDR_PAT_TWO_HIGH) begin
        next_st.pat_two_high = cfg_wdata;
      end else if (cfg_addr == OFC_ADDR_PAT_THREE_LOW) begin
        next_st.pat_three_low = cfg_wdata;
      end else if (cfg_addr == OFC_ADDR_PAT_THREE_HIGH) begin
        next_st.pat_three_high = cfg_wdata;
      end else if (cfg_addr == OFC_ADDR_PAT_FOUR_LOW) begin
        next_st.pat_four_low = cfg_wdata;
      end else if (cfg_addr == OFC_ADDR_PAT_FOUR_HIGH) begin
        next_st.pat_four_high = cfg_wdata;
      end else if (cfg_addr == OFC_ADDR_SRC_UPPER) begin
        next_st.src_upper = cfg_wdata & OFC_SRC_UPPER_MASK;
      end else if (cfg_addr == OFC_ADDR_SRC_LOWER) begin
        next_st.src_lower = cfg_wdata & OFC_SRC_LOWER_MASK;
      end else if (cfg_addr == OFC_ADDR_FORMAT) begin
        next_st.fmt = cfg_wdata & OFC_FORMAT_MASK;
      end else if (cfg_addr == OFC_ADDR_OVR_CLEAR) begin
        next_st.ovr_clear = cfg_wdata;
      end
    end
    // clear is a held level, so it beats a new event on the same converter
    next_st.ovr_status = (st.ovr_status | ovr_event) & ~st.ovr_clear;
    if (cfg_rd) begin
      next_st.rvalid = 1'b1;
      if (cfg_addr == OFC_ADDR_PAT_TWO_LOW) begin
        next_st.rdata = st.pat_two_low;
      end else if (cfg_addr == OFC_ADDR_PAT_TWO_HIGH) begin
        next_st.rdata = st.pat_two_high;
      end else if (cfg_addr == OFC_ADDR_PAT_THREE_LOW) begin
        next_st.rdata = st.pat_three_low;
      end else if (cfg_addr == OFC_ADDR_PAT_THREE_HIGH) begin
        next_st.rdata = st.pat_three_high;
      end else if (cfg_addr == OFC_ADDR_PAT_FOUR_LOW) begin
        next_st.rdata = st.pat_four_low;
      end else if (cfg_addr == OFC_ADDR_PAT_FOUR_HIGH) begin
        next_st.rdata = st.pat_four_high;
      end else if (cfg_addr == OFC_ADDR_SRC_UPPER) begin
        next_st.rdata = st.src_upper;
      end else if (cfg_addr == OFC_ADDR_SRC_LOWER) begin
        next_st.rdata = st.src_lower;
      end else if (cfg_addr == OFC_ADDR_FORMAT) begin
        next_st.rdata = st.fmt;
      end else if (cfg_addr == OFC_ADDR_OVR_CLEAR) begin
        next_st.rdata = st.ovr_clear;
      end else if (cfg_addr == OFC_ADDR_OVR_STATUS) begin
        next_st.rdata = st.ovr_status;
      end else begin
        next_st.rdata = OFC_UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
      st.pat_two_low <= OFC_RST_PATTERN;
      st.pat_two_high <= OFC_RST_PATTERN;
      st.pat_three_low <= OFC_RST_PATTERN;
      st.pat_three_high <= OFC_RST_PATTERN;
      st.pat_four_low <= OFC_RST_PATTERN;
      st.pat_four_high <= OFC_RST_PATTERN;
      st.src_upper <= OFC_RST_SRC;
      st.src_lower <= OFC_RST_SRC;
      st.fmt <= OFC_RST_FORMAT;
      st.ovr_clear <= OFC_RST_OVR_CLEAR;
      st.ovr_status <= OFC_RST_OVR_STATUS;
    end else begin
      st <= next_st;
    end
  end

  assign cfg_rdata = st.rdata;
  assign cfg_rvalid = st.rvalid;
  assign out_sample = st.smp;
  assign out_ctrl = st.ctl;
  assign out_valid = st.vld;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_PATTERN_WORD: assert property (@(posedge clk) disable iff (!rst_n)
    sample_valid && user_pattern_mode && pattern_word_sel == 2'h2
    |=> out_sample == $past(pat_word[15 -: SAMPLE_W]) && out_valid)
    else $error("pattern word four not driven");

  AST_CTRL_UNUSED_LOW: assert property (@(posedge clk) disable iff (!rst_n)
    sample_valid && !user_pattern_mode && ctrl_bit_count == 2'h0 |=> out_ctrl == 3'h0)
    else $error("control bits not low with zero count");

  AST_CTRL_SYSREF: assert property (@(posedge clk) disable iff (!rst_n)
    sample_valid && !user_pattern_mode && ctrl_bit_count != 2'h0
    && src_code[0] == OFC_SRC_SYSREF |=> out_ctrl[0] == $past(st.sysref_sync))
    else $error("control bit zero does not follow sysref");

  AST_INVERT: assert property (@(posedge clk) disable iff (!rst_n)
    sample_valid && !user_pattern_mode && st.fmt[2:0] == 3'h5
    |=> out_sample == ~$past(sample_in))
    else $error("inverted twos complement sample wrong");

  AST_CLEAR_HOLDS: assert property (@(posedge clk) disable iff (!rst_n)
    st.ovr_clear[0] ##1 st.ovr_clear[0] |-> !st.ovr_status[0])
    else $error("overrange flag set while cleared");

  // a missing set must fail here, not make a later read-back vacuous
  AST_STICKY_SET: assert property (@(posedge clk) disable iff (!rst_n)
    sample_valid && overrange_in && !st.ovr_clear[conv_idx]
    |=> st.ovr_status[$past(conv_idx)])
    else $error("overrange status not set by event");

  AST_STATUS_READBACK: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_rd && cfg_addr == OFC_ADDR_OVR_STATUS
    |=> cfg_rvalid && cfg_rdata == $past(st.ovr_status))
    else $error("overrange status not read back");

  AST_STATUS_READONLY: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_wr && cfg_addr == OFC_ADDR_OVR_STATUS && !sample_valid && st.ovr_clear == 8'h00
    |=> st.ovr_status == $past(st.ovr_status))
    else $error("status byte changed by write");

  AST_OFFSET_BINARY: assert property (@(posedge clk) disable iff (!rst_n)
    sample_valid && !user_pattern_mode && st.fmt[2:0] == 3'h0
    |=> out_sample == {~$past(sample_in[SAMPLE_W-1]), $past(sample_in[SAMPLE_W-2:0])})
    else $error("offset binary coding wrong");
endmodule

// >>> src/ofc_pkg.sv
// package: register map, field layout, reset values and codes of the output formatter
package ofc_pkg;
  localparam logic [11:0] OFC_ADDR_PAT_TWO_LOW = 12'h553;
  localparam logic [11:0] OFC_ADDR_PAT_TWO_HIGH = 12'h554;
  localparam logic [11:0] OFC_ADDR_PAT_THREE_LOW = 12'h555;
  localparam logic [11:0] OFC_ADDR_PAT_THREE_HIGH = 12'h556;
  localparam logic [11:0] OFC_ADDR_PAT_FOUR_LOW = 12'h557;
  localparam logic [11:0] OFC_ADDR_PAT_FOUR_HIGH = 12'h558;
  localparam logic [11:0] OFC_ADDR_SRC_UPPER = 12'h559;
  localparam logic [11:0] OFC_ADDR_SRC_LOWER = 12'h55A;
  localparam logic [11:0] OFC_ADDR_FORMAT = 12'h561;
  localparam logic [11:0] OFC_ADDR_OVR_CLEAR = 12'h562;
  localparam logic [11:0] OFC_ADDR_OVR_STATUS = 12'h563;

  localparam logic [7:0] OFC_RST_PATTERN = 8'h00;
  localparam logic [7:0] OFC_RST_SRC = 8'h00;
  localparam logic [7:0] OFC_RST_FORMAT = 8'h01;
  localparam logic [7:0] OFC_RST_OVR_CLEAR = 8'h00;
  localparam logic [7:0] OFC_RST_OVR_STATUS = 8'h00;
  localparam logic [7:0] OFC_UNMAPPED_READ = 8'h00;

  // field positions
  localparam int OFC_SRC_BIT0_LSB = 0;
  localparam int OFC_SRC_BIT1_LSB = 4;
  localparam int OFC_SRC_BIT2_LSB = 0;
  localparam int OFC_FMT_SEL_LSB = 0;
  localparam int OFC_INVERT_BIT = 2;
  localparam logic [7:0] OFC_SRC_UPPER_MASK = 8'h77;
  localparam logic [7:0] OFC_SRC_LOWER_MASK = 8'h07;
  localparam logic [7:0] OFC_FORMAT_MASK = 8'h07;

  // control bit source codes
  localparam logic [2:0] OFC_SRC_TIE_LOW = 3'h0;
  localparam logic [2:0] OFC_SRC_OVERRANGE = 3'h1;
  localparam logic [2:0] OFC_SRC_FAST = 3'h3;
  localparam logic [2:0] OFC_SRC_SYSREF = 3'h5;

  // sample coding
  localparam logic [1:0] OFC_FMT_OFFSET_BINARY = 2'h0;
  localparam logic [1:0] OFC_FMT_TWOS = 2'h1;

  localparam int OFC_NUM_CTRL = 3;
  localparam int OFC_NUM_CONV = 8;
endpackage

// >>> src/ofc_sel_if.sv
// interface: one control bit selector, its flags and its selected bit
`timescale 1ns/1ps
interface ofc_sel_if;
  logic [2:0] src;
  logic en;
  logic ovr;
  logic fast;
  logic sysref;
  logic bit_out;
  modport owner (output src, output en, output ovr, output fast, output sysref, input bit_out);
  modport sel (input src, input en, input ovr, input fast, input sysref, output bit_out);
endinterface

// >>> src/ofc_ctrl_sel.sv
// module: source multiplexer for one per-sample control bit
`timescale 1ns/1ps
module ofc_ctrl_sel
  import ofc_pkg::*;
(
  ofc_sel_if.sel port
);
  always_comb begin
    port.bit_out = 1'b0;
    // position unused by the control bit count stays low
    if (port.en) begin
      if (port.src == OFC_SRC_OVERRANGE) begin
        port.bit_out = port.ovr;
      end else if (port.src == OFC_SRC_FAST) begin
        port.bit_out = port.fast;
      end else if (port.src == OFC_SRC_SYSREF) begin
        port.bit_out = port.sysref;
      end
    end
  end
endmodule

// >>> verification/ofc_tb.sv
// testbench: register map, sample coding, control bit sources and sticky overrange flags
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("mismatch at %0t: got %h want %h", $time, (a), (b)); end end
module testbench;
  import ofc_pkg::*;
  localparam int W = 14;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] cfg_addr = 12'h000;
  logic [7:0] cfg_wdata = 8'h00;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [7:0] cfg_rdata;
  logic cfg_rvalid;
  logic sample_valid = 1'b0;
  logic [W-1:0] sample_in = '0;
  logic [2:0] conv_idx = 3'h0;
  logic overrange_in = 1'b0;
  logic fast_threshold_flag = 1'b0;
  logic sysref_pin = 1'b0;
  logic [1:0] ctrl_bit_count = 2'h0;
  logic user_pattern_mode = 1'b0;
  logic [1:0] pattern_word_sel = 2'h0;
  logic [W-1:0] out_sample;
  logic [2:0] out_ctrl;
  logic out_valid;
  logic [7:0] rm [12'h553:12'h563];
  logic [7:0] rd_q [$];
  logic [W+2:0] smp_q [$];
  logic [7:0] er;
  logic [W+2:0] es;
  logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h3, 3'h5};
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;

  ofc_top #(.SAMPLE_W(W)) u_ofc_top (.clk(clk), .rst_n(rst_n), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .sample_valid(sample_valid), .sample_in(sample_in),
    .conv_idx(conv_idx), .overrange_in(overrange_in), .fast_threshold_flag(fast_threshold_flag),
    .sysref_pin(sysref_pin), .ctrl_bit_count(ctrl_bit_count),
    .user_pattern_mode(user_pattern_mode), .pattern_word_sel(pattern_word_sel),
    .out_sample(out_sample), .out_ctrl(out_ctrl), .out_valid(out_valid));

  initial begin
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic bit mapped(logic [11:0] a);
    return (a >= 12'h553 && a <= 12'h55A) || (a >= 12'h561 && a <= 12'h563);
  endfunction
  function automatic logic [7:0] mask(logic [11:0] a);
    return a == 12'h559 ? 8'h77 : a == 12'h55A ? 8'h07 : a == 12'h561 ? 8'h07 : 8'hFF;
  endfunction
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    // clear bits wipe pending flags; released bits do not bring them back
    if (a == OFC_ADDR_OVR_CLEAR) rm[OFC_ADDR_OVR_STATUS] &= ~d;
    if (mapped(a) && a != OFC_ADDR_OVR_STATUS) rm[a] = d & mask(a);
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(negedge clk);
    cfg_rd = 1'b1;
    cfg_addr = a;
    rd_q.push_back(mapped(a) ? rm[a] : 8'h00);
    @(negedge clk);
    cfg_rd = 1'b0;
  endtask
  task automatic send(input logic [W-1:0] s, input logic [2:0] idx, input logic ovr, fast);
    logic [11:0] b;
    logic [15:0] word;
    logic [W-1:0] v;
    logic [2:0] c;
    logic [2:0] code;
    logic clr;
    @(negedge clk);
    sample_valid = 1'b1;
    sample_in = s;
    conv_idx = idx;
    overrange_in = ovr;
    fast_threshold_flag = fast;
    clr = rm[OFC_ADDR_OVR_CLEAR][idx];
    b = 12'h553 + {pattern_word_sel == 2'h3 ? 2'h0 : pattern_word_sel, 1'b0};
    word = {rm[b + 12'h001], rm[b]};
    v = rm[12'h561][2] ? ~s : s;
    if (rm[12'h561][1:0] == 2'h0) v[W-1] = ~v[W-1];
    for (int n = 0; n < 3; n++) begin
      code = n == 0 ? rm[12'h559][2:0] : n == 1 ? rm[12'h559][6:4] : rm[12'h55A][2:0];
      c[n] = ctrl_bit_count > n && ((code == 3'h1 && ovr && !clr) ||
        (code == 3'h3 && fast) || (code == 3'h5 && sysref_pin));
    end
    if (user_pattern_mode) begin
      v = word[15:2];
      c = {1'b0, word[1:0]};
    end
    smp_q.push_back({c, v});
    if (ovr && !clr) rm[OFC_ADDR_OVR_STATUS][idx] = 1'b1;
    // drop valid before the caller retunes modes, or a stale sample is taken
    @(negedge clk);
    sample_valid = 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk);
      sample_valid = 1'b0;
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // outputs are registered, so sampling at the falling edge avoids edge races
  always @(negedge clk) begin
    if (cfg_rvalid === 1'b1) begin
      er = rd_q.size() > 0 ? rd_q.pop_front() : 8'hXX;
      `CHK(cfg_rdata, er)
    end
    if (out_valid === 1'b1) begin
      es = smp_q.size() > 0 ? smp_q.pop_front() : 'x;
      `CHK({out_ctrl, out_sample}, es)
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      n_mismatch++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hE63BCE6C));
    foreach (rm[a]) rm[a] = 8'h00;
    rm[12'h561] = 8'h01;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    for (int a = 12'h552; a <= 12'h564; a++) rd(12'(a));
    for (int a = 12'h552; a <= 12'h564; a++) wr(12'(a), 8'($urandom));
    for (int a = 12'h552; a <= 12'h564; a++) rd(12'(a));
    user_pattern_mode = 1'b1;
    for (int w = 0; w < 4; w++) begin
      pattern_word_sel = 2'(w);
      send(W'($urandom), 3'h0, 1'b0, 1'b0);
    end
    idle(1);
    user_pattern_mode = 1'b0;
    wr(OFC_ADDR_OVR_CLEAR, 8'h00);
    for (int f = 0; f < 8; f++) begin
      wr(OFC_ADDR_FORMAT, 8'(f));
      repeat (4) send(W'($urandom), 3'h0, 1'b0, 1'b0);
    end
    for (int ci = 0; ci < 4; ci++) begin
      wr(OFC_ADDR_SRC_UPPER, {1'b0, codes[ci], 1'b0, codes[ci]});
      wr(OFC_ADDR_SRC_LOWER, {5'h00, codes[ci]});
      for (int n = 0; n < 4; n++) begin
        ctrl_bit_count = 2'(n);
        sysref_pin = 1'($urandom);
        idle(3);
        repeat (4) send(W'($urandom), 3'($urandom), 1'($urandom), 1'($urandom));
      end
    end
    idle(1);
    rd(OFC_ADDR_OVR_STATUS);
    wr(OFC_ADDR_SRC_UPPER, 8'h11);
    wr(OFC_ADDR_OVR_CLEAR, 8'hFF);
    rd(OFC_ADDR_OVR_STATUS);
    send(W'($urandom), 3'h5, 1'b1, 1'b0);
    idle(1);
    rd(OFC_ADDR_OVR_STATUS);
    wr(OFC_ADDR_OVR_CLEAR, 8'h00);
    rd(OFC_ADDR_OVR_STATUS);
    send(W'($urandom), 3'h2, 1'b1, 1'b0);
    send(W'($urandom), 3'h2, 1'b0, 1'b0);
    idle(1);
    rd(OFC_ADDR_OVR_STATUS);
    idle(4);
    `CHK(rd_q.size() + smp_q.size(), 0)
    end_sim();
  end
endmodule
